// ---- include/dbse_defs.vh ----
/*
  Constants of the data bank space expansion block: register indices,
  field positions, reset values and address windows.
  Assumes inclusion by bare name from the core files.
*/
`ifndef DBSE_DEFS_VH
`define DBSE_DEFS_VH

// Register indices; byte address is four times the index
`define DBSE_IDX_MODE_ZERO 6'h04
`define DBSE_IDX_MODE_ONE 6'h05
`define DBSE_IDX_CS_ENABLE 6'h08
`define DBSE_IDX_DATA_BANK 6'h0B
`define DBSE_IDX_STATUS 6'h0C

// Reset values
`define DBSE_RST_MODE_ZERO 8'h00
`define DBSE_RST_MODE_ONE 8'h08
`define DBSE_RST_CS_ENABLE 8'h01
`define DBSE_RST_DATA_BANK 8'h00

// Field positions
`define DBSE_PM_LO 0
`define DBSE_PM_HI 1
`define DBSE_LAYOUT_BIT 3
`define DBSE_MSM_LO 4
`define DBSE_MSM_HI 5
`define DBSE_OFS_BIT 2
`define DBSE_BANK_LO 3
`define DBSE_BANK_HI 5

// Field encodings
`define DBSE_PM_MEM_EXP 2'h1
`define DBSE_PM_MICRO 2'h3
`define DBSE_MSM_4MB 2'h3

// Banked window and offset step
`define DBSE_WIN_LO 20'h40000
`define DBSE_WIN_HI 20'hBFFFF
`define DBSE_HALF_HI 20'h7FFFF
`define DBSE_OFS_STEP 22'h040000
`define DBSE_CODE_BANK 3'h7

// Chip-select areas of the ordinary decode; area 1 ends at 3FFFF in 4 MB layout
`define DBSE_CS3_LO 20'h04000
`define DBSE_CS3_HI 20'h07FFF
`define DBSE_CS2_LO 20'h08000
`define DBSE_CS2_HI 20'h27FFF
`define DBSE_CS1_LO 20'h28000
`define DBSE_CS1_HI 20'h7FFFF
`define DBSE_CS1_HI_4MB 20'h3FFFF
`define DBSE_CS0_LO 20'h80000
`define DBSE_CS0_HI 20'hFFFFF

`endif

// ---- core/dbse_cs_decode.v ----
/*
  Ordinary chip-select decode of a 20-bit external address.
  Assumes the caller masks the result for banked and internal accesses.
*/
`include "dbse_defs.vh"

module dbse_cs_decode (
  input wire [19:0] addr_in, // Access address
  input wire [3:0] cs_en_in, // Per-area enables
  input wire mb4_in, // 4 MB layout active
  output reg [3:0] cs_n_out // Active-low selects, bit i is area i
);

  // Inclusive range test used for every area
  function in_range;
    input [19:0] a;
    input [19:0] lo;
    input [19:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  reg [19:0] cs1_top;

  // Area match; area 1 ends lower in 4 MB layout
  always @*
  begin
    cs1_top = mb4_in ? `DBSE_CS1_HI_4MB : `DBSE_CS1_HI;
    cs_n_out = 4'hF;
    if (cs_en_in[3] && in_range(addr_in, `DBSE_CS3_LO, `DBSE_CS3_HI))
      cs_n_out[3] = 1'b0;
    if (cs_en_in[2] && in_range(addr_in, `DBSE_CS2_LO, `DBSE_CS2_HI))
      cs_n_out[2] = 1'b0;
    if (cs_en_in[1] && in_range(addr_in, `DBSE_CS1_LO, cs1_top))
      cs_n_out[1] = 1'b0;
    if (cs_en_in[0] && in_range(addr_in, `DBSE_CS0_LO, `DBSE_CS0_HI))
      cs_n_out[0] = 1'b0;
  end

endmodule

// ---- core/dbse_bank_map.v ----
/*
  Banked address arithmetic for the middle window.
  Assumes the address lies inside the banked window.
*/
`include "dbse_defs.vh"

module dbse_bank_map (
  input wire [19:0] addr_in, // Access address in window
  input wire [2:0] bank_in, // Selected bank
  input wire ofs_in, // Offset flag
  output wire [2:0] bank_out, // Bank after carry
  output wire [19:0] addr_out // Address presented on the bus
);

  wire [19:0] win_off;
  wire [21:0] linear;

  // Offset inside the window, 0 to 7FFFF
  assign win_off = addr_in - `DBSE_WIN_LO;

  // Linear 4 MB address; the offset carry reaches the bank bits
  assign linear = {bank_in, 19'h00000} + {3'h0, win_off[18:0]}
    + (ofs_in ? `DBSE_OFS_STEP : 22'h000000);

  // Bank on the select pins, address kept inside the window
  assign bank_out = linear[21:19];
  assign addr_out = {linear[18], ~linear[18], linear[17:0]};

endmodule

// ---- core/dbse_top.v ----
/*
  Data bank space expansion: APB register file, mode control and
  external chip-select / address generation for 1 MB and 4 MB modes.
  Assumes a CPU access port synchronous to mclk_in and an APB master
  on the same clock; external memory sits on the select and address pins.
*/
// The APB slave port is this design's own decision.
`include "dbse_defs.vh"

module dbse_top (
  input wire mclk_in, // System clock, 50 MHz
  input wire rst_n_in, // Asynchronous reset, active low
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire pwrite_in, // APB direction, high for write
  input wire [7:0] paddr_in, // APB byte address
  input wire [31:0] pwdata_in, // APB write data
  output wire [31:0] prdata_out, // APB read data
  output wire pready_out, // APB ready
  output wire pslverr_out, // APB error for unmapped address
  input wire cpu_req_in, // CPU external bus access this cycle
  input wire cpu_fetch_in, // High for instruction fetch
  input wire [19:0] cpu_addr_in, // CPU access address
  output wire ext_req_out, // External access in progress
  output wire [19:0] ext_addr_out, // Address on the external bus
  output wire chip_select_zero_n_out, // Select 0, active low
  output wire chip_select_one_n_out, // Select 1 or bank bit 0
  output wire chip_select_two_n_out, // Select 2 or bank bit 1
  output wire chip_select_three_n_out, // Select 3 or bank bit 2
  output wire bank_active_out // Selects 3..1 carry a bank number
);

  // Register storage
  reg [7:0] processor_mode_zero_q;
  reg [7:0] processor_mode_one_q;
  reg [7:0] cs_enable_q;
  reg [7:0] data_bank_select_q;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;

  // External side registers
  reg [3:0] cs_n_q;
  reg [3:0] cs_n_d;
  reg [19:0] ext_addr_q;
  reg [19:0] ext_addr_d;
  reg ext_req_q;
  reg bank_active_q;
  reg bank_active_d;
  reg [2:0] last_bank_q;

  // Decode of the APB address
  wire [5:0] reg_idx;
  wire aligned;
  wire mapped;
  wire setup_phase;
  wire write_strobe;

  // Mode qualifiers
  wire [1:0] proc_mode;
  wire [1:0] space_mode;
  wire ext_mode;
  wire mb4;
  wire layout_half;
  wire dbr_write_ok;

  // Banked window qualifiers
  wire in_window;
  wire in_lower_half;
  wire banked;
  wire internal_gap;

  // Bank selection per access
  wire [2:0] use_bank;
  wire use_ofs;
  wire [2:0] map_bank;
  wire [19:0] map_addr;
  wire [3:0] plain_cs_n;

  // Register index from byte address; only word-aligned hits map
  assign reg_idx = paddr_in[7:2];
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign mapped = aligned && ((reg_idx == `DBSE_IDX_MODE_ZERO)
    || (reg_idx == `DBSE_IDX_MODE_ONE) || (reg_idx == `DBSE_IDX_CS_ENABLE)
    || (reg_idx == `DBSE_IDX_DATA_BANK) || (reg_idx == `DBSE_IDX_STATUS));

  // Setup cycle samples read data; access cycle commits writes
  assign setup_phase = psel_in && !penable_in;
  assign write_strobe = psel_in && penable_in && pwrite_in && mapped;

  // Zero-wait slave; error only for unmapped addresses
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = prdata_q;

  // Mode fields
  assign proc_mode = processor_mode_zero_q[`DBSE_PM_HI:`DBSE_PM_LO];
  assign space_mode = processor_mode_one_q[`DBSE_MSM_HI:`DBSE_MSM_LO];

  // External bus exists only in expansion or microprocessor mode
  assign ext_mode = (proc_mode == `DBSE_PM_MEM_EXP)
    || (proc_mode == `DBSE_PM_MICRO);

  // 4 MB layout needs both the space field and an external mode
  assign mb4 = ext_mode && (space_mode == `DBSE_MSM_4MB);

  // Half-bank layout applies only in memory expansion mode
  assign layout_half = processor_mode_one_q[`DBSE_LAYOUT_BIT]
    && (proc_mode == `DBSE_PM_MEM_EXP);

  // Bank register writes are held off outside 4 MB space mode
  assign dbr_write_ok = (space_mode == `DBSE_MSM_4MB);

  // Middle window test
  assign in_window = (cpu_addr_in >= `DBSE_WIN_LO)
    && (cpu_addr_in <= `DBSE_WIN_HI);
  assign in_lower_half = (cpu_addr_in <= `DBSE_HALF_HI);

  // Half layout banks only the lower part; the upper part is internal
  assign banked = mb4 && in_window && (!layout_half || in_lower_half);
  assign internal_gap = mb4 && in_window && layout_half && !in_lower_half;

  // Fetches use the code bank without offset; data uses the register
  assign use_bank = cpu_fetch_in ? `DBSE_CODE_BANK
    : data_bank_select_q[`DBSE_BANK_HI:`DBSE_BANK_LO];
  assign use_ofs = cpu_fetch_in ? 1'b0
    : data_bank_select_q[`DBSE_OFS_BIT];

  // Banked address arithmetic
  dbse_bank_map u_bank_map (
    .addr_in(cpu_addr_in),
    .bank_in(use_bank),
    .ofs_in(use_ofs),
    .bank_out(map_bank),
    .addr_out(map_addr)
  );

  // Ordinary area decode
  dbse_cs_decode u_cs_decode (
    .addr_in(cpu_addr_in),
    .cs_en_in(cs_enable_q[3:0]),
    .mb4_in(mb4),
    .cs_n_out(plain_cs_n)
  );

  // Next select pattern, address and bank flag for the bus
  always @*
  begin
    cs_n_d = 4'hF;
    ext_addr_d = ext_addr_q;
    bank_active_d = 1'b0;
    if (cpu_req_in && ext_mode)
    begin
      if (banked)
      begin
        cs_n_d = {map_bank, 1'b0};
        ext_addr_d = map_addr;
        bank_active_d = 1'b1;
      end
      else if (internal_gap)
      begin
        cs_n_d = 4'hF;
        ext_addr_d = ext_addr_q;
      end
      else
      begin
        cs_n_d = plain_cs_n;
        ext_addr_d = cpu_addr_in;
      end
    end
  end

  // Read data multiplexer, narrow registers in the low byte
  always @*
  begin
    prdata_d = 32'h00000000;
    if (aligned)
    begin
      case (reg_idx)
        `DBSE_IDX_MODE_ZERO: prdata_d = {24'h000000, processor_mode_zero_q};
        `DBSE_IDX_MODE_ONE: prdata_d = {24'h000000, processor_mode_one_q};
        `DBSE_IDX_CS_ENABLE: prdata_d = {24'h000000, cs_enable_q};
        `DBSE_IDX_DATA_BANK: prdata_d = {24'h000000, data_bank_select_q};
        `DBSE_IDX_STATUS: prdata_d = {24'h000000, last_bank_q, 2'h0,
          bank_active_q, mb4, ext_mode};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // Read data captured in the setup cycle, stable through access
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      prdata_q <= 32'h00000000;
    else if (setup_phase)
      prdata_q <= prdata_d;
  end

  // Mode registers
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      processor_mode_zero_q <= `DBSE_RST_MODE_ZERO;
      processor_mode_one_q <= `DBSE_RST_MODE_ONE;
      cs_enable_q <= `DBSE_RST_CS_ENABLE;
    end
    else if (write_strobe)
    begin
      if (reg_idx == `DBSE_IDX_MODE_ZERO)
        processor_mode_zero_q <= pwdata_in[7:0];
      if (reg_idx == `DBSE_IDX_MODE_ONE)
        processor_mode_one_q <= pwdata_in[7:0];
      if (reg_idx == `DBSE_IDX_CS_ENABLE)
        cs_enable_q <= {4'h0, pwdata_in[3:0]};
    end
  end

  // Bank register, guarded by the space mode field
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      data_bank_select_q <= `DBSE_RST_DATA_BANK;
    else if (write_strobe && (reg_idx == `DBSE_IDX_DATA_BANK) && dbr_write_ok)
      data_bank_select_q <= {2'h0, pwdata_in[`DBSE_BANK_HI:`DBSE_BANK_LO],
        pwdata_in[`DBSE_OFS_BIT], 2'h0};
  end

  // External bus outputs, one cycle after the CPU request
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cs_n_q <= 4'hF;
      ext_addr_q <= 20'h00000;
      ext_req_q <= 1'b0;
      bank_active_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= cs_n_d;
      ext_addr_q <= ext_addr_d;
      ext_req_q <= cpu_req_in && ext_mode && !internal_gap;
      bank_active_q <= bank_active_d;
    end
  end

  // Last bank driven, for software inspection
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      last_bank_q <= 3'h0;
    else if (bank_active_d)
      last_bank_q <= map_bank;
  end

  // Pin outputs
  assign ext_req_out = ext_req_q;
  assign ext_addr_out = ext_addr_q;
  assign chip_select_zero_n_out = cs_n_q[0];
  assign chip_select_one_n_out = cs_n_q[1];
  assign chip_select_two_n_out = cs_n_q[2];
  assign chip_select_three_n_out = cs_n_q[3];
  assign bank_active_out = bank_active_q;

endmodule

// ---- verification/dbse_assertions.sv ----
/*
  Checker of the data bank expansion block, bound to its top module.
  Assumes the top module ports as declared by the design.
*/
module dbse_checker (
  input wire mclk_in, // Clock
  input wire rst_n_in, // Reset, active low
  input wire pslverr_out, // APB error
  input wire psel_in, // APB select
  input wire penable_in, // APB enable
  input wire cpu_req_in, // CPU access
  input wire cpu_fetch_in, // Fetch flag
  input wire [19:0] cpu_addr_in, // CPU address
  input wire ext_req_out, // External access
  input wire [19:0] ext_addr_out, // Bus address
  input wire chip_select_zero_n_out, // Select 0
  input wire chip_select_one_n_out, // Select 1
  input wire chip_select_two_n_out, // Select 2
  input wire chip_select_three_n_out, // Select 3
  input wire bank_active_out // Bank on selects
);
  // Selects as one vector and the banked window decode
  wire [3:0] sel_n = {chip_select_three_n_out, chip_select_two_n_out,
    chip_select_one_n_out, chip_select_zero_n_out};
  wire in_win = cpu_addr_in >= 20'h40000 && cpu_addr_in <= 20'hBFFFF;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Request kinds
  sequence out_req; cpu_req_in && !in_win; endsequence
  sequence fetch_req; cpu_req_in && cpu_fetch_in && in_win; endsequence
  AST_IDLE: assert property (!cpu_req_in |=> sel_n == 4'hF && !ext_req_out)
    else $error("select active without a request");
  AST_REQ_CAUSE: assert property (ext_req_out |-> $past(cpu_req_in))
    else $error("external access without a request");
  AST_ONE_SEL: assert property (ext_req_out && !bank_active_out |-> $onehot0(~sel_n))
    else $error("more than one area selected");
  AST_BANK_CS0: assert property (bank_active_out |-> !chip_select_zero_n_out && ext_req_out)
    else $error("banked access without select zero");
  AST_BANK_CAUSE: assert property (bank_active_out |-> $past(in_win) && $past(cpu_req_in))
    else $error("bank output outside the window");
  AST_OUTSIDE: assert property (out_req |=> !bank_active_out)
    else $error("bank output for an ordinary area");
  AST_FETCH_BANK: assert property (fetch_req |=> !bank_active_out || sel_n[3:1] == 3'h7)
    else $error("fetch not from the code bank");
  AST_ADDR_SPLIT: assert property (bank_active_out |-> ext_addr_out[19] != ext_addr_out[18])
    else $error("banked bus address bits wrong");
  AST_ERR_PHASE: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside the access phase");
endmodule

bind dbse_top dbse_checker u_dbse_checker (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .pslverr_out(pslverr_out), .psel_in(psel_in), .penable_in(penable_in),
  .cpu_req_in(cpu_req_in), .cpu_fetch_in(cpu_fetch_in), .cpu_addr_in(cpu_addr_in),
  .ext_req_out(ext_req_out), .ext_addr_out(ext_addr_out),
  .chip_select_zero_n_out(chip_select_zero_n_out),
  .chip_select_one_n_out(chip_select_one_n_out),
  .chip_select_two_n_out(chip_select_two_n_out),
  .chip_select_three_n_out(chip_select_three_n_out), .bank_active_out(bank_active_out));

// ---- verification/dbse_ext_mem.sv ----
/*
  External 4 MB memory as seen on the select and address pins.
  Assumes select 0 enables the part and selects 3..1 feed its top bits.
*/
module dbse_ext_mem (
  input wire cs0_n_in, // Part enable, active low
  input wire [2:0] bank_in, // Selects 3..1 as address bits
  input wire [19:0] addr_in, // Bus address
  output logic hit_out, // Part selected
  output logic [21:0] lin_out // Address seen by the part
);
  // Bus bit 18 is unwired, bus bit 19 feeds memory bit 18
  always_comb
  begin
    hit_out = !cs0_n_in;
    lin_out = hit_out ? {bank_in, addr_in[19], addr_in[17:0]} : 22'h3FFFFF;
  end
endmodule

// ---- verification/tb_dbse_top.sv ----
/*
  Testbench of the data bank expansion block: APB set-up, then CPU
  accesses checked against the banked address map.
  Assumes the design core files and the external memory model.
*/
module tb_dbse_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic psel_in = 1'h0;
  logic penable_in = 1'h0;
  logic pwrite_in = 1'h0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic cpu_req_in = 1'h0;
  logic cpu_fetch_in = 1'h0;
  logic [19:0] cpu_addr_in = 20'h0;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, ext_req_out, bank_active_out, cs0_n, cs1_n, cs2_n, cs3_n, hit;
  wire [19:0] ext_addr_out;
  wire [21:0] lin;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  // Block under test and the memory on its far side
  dbse_top u_dbse_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .cpu_req_in(cpu_req_in), .cpu_fetch_in(cpu_fetch_in),
    .cpu_addr_in(cpu_addr_in), .ext_req_out(ext_req_out), .ext_addr_out(ext_addr_out),
    .chip_select_zero_n_out(cs0_n), .chip_select_one_n_out(cs1_n),
    .chip_select_two_n_out(cs2_n), .chip_select_three_n_out(cs3_n),
    .bank_active_out(bank_active_out));
  dbse_ext_mem u_dbse_ext_mem (.cs0_n_in(cs0_n), .bank_in({cs3_n, cs2_n, cs1_n}),
    .addr_in(ext_addr_out), .hit_out(hit), .lin_out(lin));
  // Clock and cycle ceiling against a hung run
  always #10 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_in);
    psel_in <= 1'h1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge mclk_in);
    penable_in <= 1'h1;
    @(posedge mclk_in);
    while (pready_out !== 1'h1)
      @(posedge mclk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'h0, a, 32'h0);
    chk(rd, d);
    chk({31'h0, err}, {31'h0, e});
  endtask
  // One CPU access; e is {ext_req, bank_active, selects 3..0}
  task automatic acc(input logic [19:0] a, input logic f, input logic [5:0] e,
    input logic [19:0] ea);
    @(posedge mclk_in);
    cpu_req_in <= 1'h1;
    cpu_addr_in <= a;
    cpu_fetch_in <= f;
    @(posedge mclk_in);
    cpu_req_in <= 1'h0;
    #1;
    chk({26'h0, ext_req_out, bank_active_out, cs3_n, cs2_n, cs1_n, cs0_n}, {26'h0, e});
    if (e[5])
      chk({12'h0, ext_addr_out}, {12'h0, ea});
  endtask
  // Banked access against the linear memory address
  task automatic bk(input logic [2:0] b, input logic o, input logic [19:0] a, input logic f);
    logic [21:0] l;
    l = {b, 19'h0} + {2'h0, a - 20'h40000} + (o ? 22'h040000 : 22'h0);
    acc(a, f, {2'h3, l[21:19], 1'h0}, {l[18], ~l[18], l[17:0]});
    chk({9'h0, hit, lin}, {9'h0, 1'h1, l});
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    rdchk(8'h10, 32'h00, 1'h0);
    rdchk(8'h14, 32'h08, 1'h0);
    rdchk(8'h20, 32'h01, 1'h0);
    rdchk(8'h2C, 32'h00, 1'h0);
    rdchk(8'h30, 32'h00, 1'h0);
    rdchk(8'h40, 32'h00, 1'h1);
    rdchk(8'h15, 32'h00, 1'h1);
    apb(1'h1, 8'h2C, 32'h10);
    rdchk(8'h2C, 32'h00, 1'h0);
    apb(1'h1, 8'h14, 32'h30);
    apb(1'h1, 8'h2C, 32'h10);
    rdchk(8'h2C, 32'h10, 1'h0);
    acc(20'h40000, 1'h0, 6'h0F, 20'h0);
    // Program ROM 1 is never mapped here, so microprocessor mode starts at once
    apb(1'h1, 8'h10, 32'h03);
    apb(1'h1, 8'h20, 32'h0F);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'h1, 8'h2C, {26'h0, i[3:1], i[0], 2'h0});
      bk(i[3:1], i[0], 20'h40000, 1'h0);
      bk(i[3:1], i[0], 20'hBFFFF, 1'h0);
    end
    apb(1'h1, 8'h2C, 32'h10);
    bk(3'h7, 1'h0, 20'h60000, 1'h1);
    rdchk(8'h30, 32'hE3, 1'h0);
    acc(20'h3FFFF, 1'h0, 6'h2D, 20'h3FFFF);
    acc(20'h04000, 1'h0, 6'h27, 20'h04000);
    acc(20'hC0000, 1'h0, 6'h2E, 20'hC0000);
    apb(1'h1, 8'h10, 32'h01);
    apb(1'h1, 8'h14, 32'h38);
    apb(1'h1, 8'h2C, 32'h14);
    bk(3'h2, 1'h1, 20'h40000, 1'h0);
    bk(3'h2, 1'h1, 20'h7FFFF, 1'h0);
    acc(20'h80000, 1'h0, 6'h0F, 20'h0);
    // Layout bit in microprocessor mode keeps the full 512 KB banks
    apb(1'h1, 8'h10, 32'h03);
    bk(3'h2, 1'h1, 20'hBFFFF, 1'h0);
    apb(1'h1, 8'h14, 32'h00);
    acc(20'h50000, 1'h0, 6'h2D, 20'h50000);
    acc(20'h90000, 1'h0, 6'h2E, 20'h90000);
    // Disabled area: access goes out with no select
    apb(1'h1, 8'h20, 32'h01);
    acc(20'h50000, 1'h0, 6'h2F, 20'h50000);
    // Processor mode 10 gives no external outputs
    apb(1'h1, 8'h10, 32'h02);
    acc(20'hC0000, 1'h0, 6'h0F, 20'h0);
    // Mid-run reset returns the registers to their reset values
    @(posedge mclk_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    rdchk(8'h14, 32'h08, 1'h0);
    rdchk(8'h2C, 32'h00, 1'h0);
    rdchk(8'h30, 32'h00, 1'h0);
    test_done();
  end
endmodule
